// ### design/lfd_debounce.sv
`timescale 1ns/1ns
module lfd_debounce #(
    parameter int STABLE_CYC = lfd_pkg::DEBOUNCE_CYC
) (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               din,
    output lfd_pkg::lfd_deb_type    dout
);
    import lfd_pkg::*;

    // ----------------------------------------------------------------
    // Elaboration check
    // ----------------------------------------------------------------
    if (STABLE_CYC < 1 || STABLE_CYC >= (1 << DEB_CNT_W)) begin : g_chk
        $error("lfd_debounce: STABLE_CYC out of range");
    end

    localparam logic [DEB_CNT_W-1:0] CNT_LAST = DEB_CNT_W'(STABLE_CYC - 1);

    typedef struct packed {
        logic                 sample;
        logic                 stable;
        logic [DEB_CNT_W-1:0] cnt;
        logic                 rise;
        logic                 fall;
    } lfd_deb_state_type;

    lfd_deb_state_type state_reg;
    lfd_deb_state_type state_next;

    // ----------------------------------------------------------------
    // Filter
    // ----------------------------------------------------------------
    // Restart on any change, accept after a full quiet interval
    always_comb begin
        state_next        = state_reg;
        state_next.sample = din;
        state_next.rise   = 1'b0;
        state_next.fall   = 1'b0;
        if (din != state_reg.sample) begin
            state_next.cnt = '0;
        end else if (din != state_reg.stable) begin
            if (state_reg.cnt == CNT_LAST) begin
                state_next.stable = din;
                state_next.rise   = din;
                state_next.fall   = ~din;
                state_next.cnt    = '0;
            end else begin
                state_next.cnt = state_reg.cnt + 1'b1;
            end
        end else begin
            state_next.cnt = '0;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign dout.level = state_reg.stable;
    assign dout.rise  = state_reg.rise;
    assign dout.fall  = state_reg.fall;

endmodule // lfd_debounce

// ### design/lfd_pkg.sv
package lfd_pkg;

    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ           = 20_000_000;
    localparam int DEBOUNCE_MS      = 37;
    localparam int DEBOUNCE_CYC     = DEBOUNCE_MS * (CLK_HZ / 1000);
    localparam int PWM_HZ           = 220;
    localparam int INSTANT_US       = 70;
    localparam int GAMMA_STEPS      = 63;
    localparam int GAMMA_FULL       = 1000;
    // Cycles per phase tick of the internal PWM (1000 ticks per period)
    localparam int PWM_TICK_CYC     = CLK_HZ / (PWM_HZ * GAMMA_FULL);
    // Cycles per gamma step for an instant transition, rounded down
    localparam int INSTANT_STEP_CYC = (INSTANT_US * (CLK_HZ / 1_000_000)) / GAMMA_STEPS;
    localparam int DEB_CNT_W        = 20;
    localparam int TICK_CNT_W       = 16;

    localparam logic [5:0] LEVEL_TOP = 6'h3e;
    localparam logic [9:0] PHASE_TOP = 10'h3e7;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [11:0] CONFIG_ADDR    = 12'h000;
    localparam logic [11:0] FADE_TIME_ADDR = 12'h004;
    localparam logic [11:0] STATUS_ADDR    = 12'h008;

    localparam int CFG_SWITCH_STYLE_BIT = 0;
    localparam int CFG_DIM_SOURCE_BIT   = 1;
    localparam int CFG_POLARITY_BIT     = 2;
    localparam logic [2:0] CONFIG_RESET = 3'h5;

    localparam int FADE_RISE_LSB = 0;
    localparam int FADE_FALL_LSB = 8;
    localparam logic [7:0] FADE_RISE_RESET = 8'h01;
    localparam logic [7:0] FADE_FALL_RESET = 8'h01;

    localparam int STAT_LEVEL0_LSB = 0;
    localparam int STAT_LEVEL1_LSB = 8;
    localparam int STAT_TARGET_LSB = 16;
    localparam int STAT_OUT_LSB    = 18;
    localparam int STAT_AUX_BIT    = 20;

    // Gamma intensity per ramp step, on a 1000-step linear scale
    localparam logic [9:0] GAMMA_TABLE [GAMMA_STEPS] = '{
        10'd0,   10'd2,   10'd4,   10'd6,   10'd8,   10'd10,  10'd12,  10'd16,
        10'd20,  10'd24,  10'd28,  10'd32,  10'd36,  10'd42,  10'd48,  10'd54,
        10'd60,  10'd66,  10'd72,  10'd80,  10'd88,  10'd96,  10'd104, 10'd112,
        10'd120, 10'd130, 10'd140, 10'd150, 10'd160, 10'd170, 10'd180, 10'd194,
        10'd208, 10'd222, 10'd236, 10'd250, 10'd264, 10'd282, 10'd300, 10'd318,
        10'd336, 10'd354, 10'd372, 10'd394, 10'd416, 10'd438, 10'd460, 10'd482,
        10'd504, 10'd534, 10'd564, 10'd594, 10'd624, 10'd654, 10'd684, 10'd722,
        10'd760, 10'd798, 10'd836, 10'd874, 10'd914, 10'd956, 10'd1000
    };

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } lfd_apb_req_type;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } lfd_apb_rsp_type;

    typedef struct packed {
        logic level;
        logic rise;
        logic fall;
    } lfd_deb_type;

endpackage

// ### design/lfd_top.sv
// What this block does
// - Switch style selects pulse or level mode
// - Main channels ramp through 63 gamma steps
// - New toggle reverses a running ramp
// - Pulse mode: debounced low flips channel latch
// - Both main channels start off after reset
// - Level mode: debounced high fades up, holds
// - Level mode: debounced low fades down, holds
// - Separate rise and fall fade time settings
// - Debounce both edges of switch inputs
// - Aux output follows enable, no fade
// - Aux low turns off; PWM does not gate it
// - Dim input drives both main channels alike
// - Dim source selects external or internal
// - Positive polarity: high dim level is active
// - Negative polarity: low dim level is active
// - External dim bypasses ramps, instant on/off
// - External average current follows duty cycle
// - Internal dim: debounced change starts joint fade
// - Internal ramps use about 220Hz PWM
// - Active fades up or holds; inactive down
// - Zero fade setting gives about 70us transition
// - Steps map to 1000-scale gamma table
`timescale 1ns/1ns
module lfd_top #(
    parameter int DEBOUNCE_CYC = lfd_pkg::DEBOUNCE_CYC,
    parameter int PWM_TICK_CYC = lfd_pkg::PWM_TICK_CYC
) (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  lfd_pkg::lfd_apb_req_type apb_req,
    output lfd_pkg::lfd_apb_rsp_type apb_rsp,
    input  wire logic [1:0]         channel_toggle_input,
    input  wire logic               aux_enable_input,
    input  wire logic               dim_input,
    output logic [1:0]              main_led_channel,
    output logic                    aux_led_channel
);
    import lfd_pkg::*;

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    if (PWM_TICK_CYC < 1 || PWM_TICK_CYC >= (1 << TICK_CNT_W)) begin : g_chk_tick
        $error("lfd_top: PWM_TICK_CYC out of range");
    end
    if (INSTANT_STEP_CYC < 1 || INSTANT_STEP_CYC > 31) begin : g_chk_inst
        $error("lfd_top: INSTANT_STEP_CYC out of range");
    end

    localparam logic [TICK_CNT_W-1:0] TICK_LAST = TICK_CNT_W'(PWM_TICK_CYC - 1);
    localparam logic [4:0]            INST_LAST = 5'(INSTANT_STEP_CYC - 1);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0]            cfg;
        logic [7:0]            rise_time_set;
        logic [7:0]            fall_time_set;
        logic                  pready;
        logic                  pslverr;
        logic [31:0]           prdata;
        logic [TICK_CNT_W-1:0] tick_cnt;
        logic [9:0]            phase;
        logic [4:0]            inst_cnt;
        logic [1:0]            target;
        logic [1:0][5:0]       level;
        logic [1:0][7:0]       step_cnt;
        logic [1:0]            main_out;
        logic                  aux_out;
    } lfd_state_type;

    lfd_state_type state_reg;
    lfd_state_type state_next;

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    // Gamma intensity for a ramp step
    function automatic logic [9:0] gamma_of(input logic [5:0] lvl);
        gamma_of = GAMMA_TABLE[lvl];
    endfunction

    // Register decode: 0 config, 1 fade time, 2 status, 3 unmapped
    function automatic logic [1:0] reg_sel(input logic [11:0] addr);
        case (addr)
            CONFIG_ADDR:    reg_sel = 2'h0;
            FADE_TIME_ADDR: reg_sel = 2'h1;
            STATUS_ADDR:    reg_sel = 2'h2;
            default:        reg_sel = 2'h3;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Debounce filters: two switches and the dim input
    // ----------------------------------------------------------------
    lfd_deb_type deb_ch [2];
    lfd_deb_type deb_dim;
    logic        switch_pulse_mode;
    logic        dim_external;
    logic        dim_positive;
    logic        dim_active;

    assign switch_pulse_mode = state_reg.cfg[CFG_SWITCH_STYLE_BIT];
    assign dim_external      = state_reg.cfg[CFG_DIM_SOURCE_BIT];
    assign dim_positive      = state_reg.cfg[CFG_POLARITY_BIT];
    // Active level: high for positive, low for negative polarity
    assign dim_active        = dim_positive ? dim_input : ~dim_input;

    for (genvar ch = 0; ch < 2; ch++) begin : g_deb
        lfd_debounce #(
            .STABLE_CYC (DEBOUNCE_CYC)
        ) u_deb_ch (
            .clk  (clk),
            .rst_n(rst_n),
            .din  (channel_toggle_input[ch]),
            .dout (deb_ch[ch])
        );
    end

    lfd_debounce #(
        .STABLE_CYC (DEBOUNCE_CYC)
    ) u_deb_dim (
        .clk  (clk),
        .rst_n(rst_n),
        .din  (dim_active),
        .dout (deb_dim)
    );

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        logic       apb_access;
        logic [1:0] sel;
        logic       tick;
        logic       pwm_wrap;
        logic       inst_tick;
        logic       ramp_up;
        logic       ramp_down;
        logic [7:0] time_set;
        logic [7:0] step_lim;
        logic       unit;

        state_next = state_reg;
        apb_access = 1'b0;
        sel        = 2'h0;
        tick       = 1'b0;
        pwm_wrap   = 1'b0;
        inst_tick  = 1'b0;
        ramp_up    = 1'b0;
        ramp_down  = 1'b0;
        time_set   = 8'h00;
        step_lim   = 8'h00;
        unit       = 1'b0;

        // APB slave: one wait state, then pready for one cycle
        apb_access         = apb_req.psel & apb_req.penable;
        sel                = reg_sel(apb_req.paddr);
        state_next.pready  = 1'b0;
        state_next.pslverr = 1'b0;
        if (apb_access && !state_reg.pready) begin
            state_next.pready  = 1'b1;
            state_next.pslverr = (sel == 2'h3);
            state_next.prdata  = 32'h0000_0000;
            if (!apb_req.pwrite) begin
                case (sel)
                    2'h0: state_next.prdata[2:0] = state_reg.cfg;
                    2'h1: begin
                        state_next.prdata[FADE_RISE_LSB +: 8] = state_reg.rise_time_set;
                        state_next.prdata[FADE_FALL_LSB +: 8] = state_reg.fall_time_set;
                    end
                    2'h2: begin
                        state_next.prdata[STAT_LEVEL0_LSB +: 6] = state_reg.level[0];
                        state_next.prdata[STAT_LEVEL1_LSB +: 6] = state_reg.level[1];
                        state_next.prdata[STAT_TARGET_LSB +: 2] = state_reg.target;
                        state_next.prdata[STAT_OUT_LSB +: 2]    = state_reg.main_out;
                        state_next.prdata[STAT_AUX_BIT]         = state_reg.aux_out;
                    end
                    default: state_next.prdata = 32'h0000_0000;
                endcase
            end
        end
        // Writes land on the completing edge only
        if (apb_access && state_reg.pready && apb_req.pwrite) begin
            case (sel)
                2'h0: state_next.cfg = apb_req.pwdata[2:0];
                2'h1: begin
                    state_next.rise_time_set = apb_req.pwdata[FADE_RISE_LSB +: 8];
                    state_next.fall_time_set = apb_req.pwdata[FADE_FALL_LSB +: 8];
                end
                default: state_next.cfg = state_reg.cfg;
            endcase
        end

        // Internal PWM timebase: 1000 phase ticks per period
        tick = (state_reg.tick_cnt == TICK_LAST);
        state_next.tick_cnt = tick ? '0 : state_reg.tick_cnt + 1'b1;
        if (tick) begin
            state_next.phase = (state_reg.phase == PHASE_TOP) ? 10'h000 : state_reg.phase + 1'b1;
        end
        pwm_wrap = tick && (state_reg.phase == PHASE_TOP);

        // Short step timer for instant transitions
        inst_tick = (state_reg.inst_cnt == INST_LAST);
        state_next.inst_cnt = inst_tick ? 5'h00 : state_reg.inst_cnt + 1'b1;

        // Channel latches from the switch inputs
        for (int ch = 0; ch < 2; ch++) begin
            if (switch_pulse_mode) begin
                if (deb_ch[ch].fall) begin
                    state_next.target[ch] = ~state_reg.target[ch];
                end
            end else begin
                if (deb_ch[ch].rise) begin
                    state_next.target[ch] = 1'b1;
                end
                if (deb_ch[ch].fall) begin
                    state_next.target[ch] = 1'b0;
                end
            end
        end
        // Internal dimming overrides the switches for both channels
        if (!dim_external) begin
            if (deb_dim.rise) begin
                state_next.target = 2'b11;
            end
            if (deb_dim.fall) begin
                state_next.target = 2'b00;
            end
        end

        // Ramp engines, direction from the current latch
        for (int ch = 0; ch < 2; ch++) begin
            ramp_up   = state_reg.target[ch] && (state_reg.level[ch] != LEVEL_TOP);
            ramp_down = !state_reg.target[ch] && (state_reg.level[ch] != 6'h00);
            time_set  = state_reg.target[ch] ? state_reg.rise_time_set
                                             : state_reg.fall_time_set;
            step_lim  = (time_set == 8'h00) ? 8'h01 : time_set;
            unit      = (time_set == 8'h00) ? inst_tick : pwm_wrap;
            if (!(ramp_up || ramp_down)) begin
                state_next.step_cnt[ch] = 8'h00;
            end else if (unit) begin
                if (state_reg.step_cnt[ch] + 8'h01 >= step_lim) begin
                    state_next.step_cnt[ch] = 8'h00;
                    if (ramp_up) begin
                        state_next.level[ch] = state_reg.level[ch] + 1'b1;
                    end else begin
                        state_next.level[ch] = state_reg.level[ch] - 1'b1;
                    end
                end else begin
                    state_next.step_cnt[ch] = state_reg.step_cnt[ch] + 8'h01;
                end
            end

            // Output: raw dim level externally, gamma PWM internally
            if (dim_external) begin
                state_next.main_out[ch] = dim_active;
            end else begin
                state_next.main_out[ch] = gamma_of(state_reg.level[ch]) > state_reg.phase;
            end
        end

        // Aux channel passes its enable straight through
        state_next.aux_out = aux_enable_input;
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg               <= '0;
            state_reg.cfg           <= CONFIG_RESET;
            state_reg.rise_time_set <= FADE_RISE_RESET;
            state_reg.fall_time_set <= FADE_FALL_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign apb_rsp.pready    = state_reg.pready;
    assign apb_rsp.pslverr   = state_reg.pslverr;
    assign apb_rsp.prdata    = state_reg.prdata;
    assign main_led_channel  = state_reg.main_out;
    assign aux_led_channel   = state_reg.aux_out;

endmodule // lfd_top

// ### tb/led_fade_dimming_control_bench.sv
`timescale 1ns/1ns
module led_fade_dimming_control_bench;
    import lfd_pkg::*;
    localparam int DEB = 8;
    localparam int TICK = 2;
    localparam int SETTLE = DEB + 12;
    localparam int RAMP = 1500;
    logic            clk = 1'b0;
    logic            rst_n;
    lfd_apb_req_type apb_req;
    lfd_apb_rsp_type apb_rsp;
    logic [2:0]      lvl;
    logic [2:0]      pin;
    logic            chat;
    logic            aux_en = 1'b0;
    logic            aux_out;
    logic [1:0]      main;
    logic [31:0]     seed = 32'h553d830f;
    logic [31:0]     rd;
    logic            err;
    logic            pd;
    logic            pa;
    int              fails = 0;
    int              checked = 0;
    int              hi0;
    int              hi1;

    always #25 clk = ~clk;

    lfd_switch_model #(.W(3)) i_lfd_switch_model (
        .clk(clk), .level(lvl), .chatter(chat), .pin(pin));
    lfd_top #(.DEBOUNCE_CYC(DEB), .PWM_TICK_CYC(TICK)) i_lfd_top (
        .clk(clk), .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .channel_toggle_input(pin[1:0]), .aux_enable_input(aux_en),
        .dim_input(pin[2]), .main_led_channel(main), .aux_led_channel(aux_out));

    // ----
    // Helpers
    // ----
    function logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function logic [1:0] ext_exp(input logic d, input logic polarity_select);
        return {2{d ~^ polarity_select}};
    endfunction
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
        int n;
        @(posedge clk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: data};
        @(posedge clk);
        apb_req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 50);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        chk("pready", 32'h1, {31'h0, apb_rsp.pready});
        apb_req <= '0;
    endtask
    task rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input string s);
        apb(1'b0, a, 32'h0);
        chk(s, e, rd & m);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task press(input int ch);
        lvl[ch] <= 1'b0;
        wt(SETTLE);
        lvl[ch] <= 1'b1;
        wt(SETTLE);
    endtask
    task report_and_stop;
        $display("Comparisons %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Random aux enable throughout the run
    always @(posedge clk) begin
        seed <= lfsr(seed);
        aux_en <= seed[3];
    end

    // Watchdog
    initial begin
        wt(40000);
        fails++;
        report_and_stop();
    end

    // ----
    // Main sequence
    // ----
    initial begin
        rst_n = 1'b0;
        apb_req = '0;
        lvl = 3'b000;
        chat = 1'b1;
        wt(3);
        rst_n <= 1'b1;
        rdc(CONFIG_ADDR, 32'h7, 32'h5, "config_rst");
        rdc(FADE_TIME_ADDR, 32'hffff, 32'h0101, "fade_rst");
        rdc(STATUS_ADDR, 32'hfffff, 32'h0, "status_rst");
        apb(1'b0, 12'hffc, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, err});
        chk("unmapped_data", 32'h0, rd);
        apb(1'b1, STATUS_ADDR, 32'hffffffff);
        rdc(STATUS_ADDR, 32'hfffff, 32'h0, "status_ro");
        apb(1'b1, FADE_TIME_ADDR, 32'h0);
        lvl[1:0] <= 2'b11;
        wt(SETTLE);
        rdc(STATUS_ADDR, 32'h30000, 32'h0, "rise_no_flip");
        press(0);
        rdc(STATUS_ADDR, 32'h30000, 32'h10000, "press_flip");
        wt(RAMP);
        rdc(STATUS_ADDR, 32'h3f3f, 32'h3e, "ramp_top");
        hi0 = 0;
        hi1 = 0;
        repeat (1000 * TICK) begin
            @(posedge clk);
            hi0 += int'(main[0]);
            hi1 += int'(main[1]);
        end
        chk("duty0", GAMMA_TABLE[62] * TICK, hi0);
        chk("duty1", 32'h0, hi1);
        chat <= 1'b0;
        lvl[0] <= 1'b0;
        wt(4);
        lvl[0] <= 1'b1;
        wt(SETTLE);
        chat <= 1'b1;
        rdc(STATUS_ADDR, 32'h30000, 32'h10000, "glitch");
        press(1);
        wt(200);
        press(1);
        rdc(STATUS_ADDR, 32'h30000, 32'h10000, "reverse_latch");
        chk("reverse_mid", 32'h1, {31'h0, rd[13:8] > 6'h0 && rd[13:8] < LEVEL_TOP});
        apb(1'b1, FADE_TIME_ADDR, 32'h100);
        press(0);
        wt(RAMP);
        rdc(STATUS_ADDR, 32'h30000, 32'h0, "slow_fall_rd");
        chk("slow_fall", 32'h1, {31'h0, rd[5:0] > 6'd50});
        apb(1'b1, FADE_TIME_ADDR, 32'h0);
        wt(RAMP);
        rdc(STATUS_ADDR, 32'h33f3f, 32'h0, "all_off");
        apb(1'b1, CONFIG_ADDR, 32'h4);
        lvl[1:0] <= 2'b00;
        wt(SETTLE);
        rdc(STATUS_ADDR, 32'h30000, 32'h0, "lvl_keep_off");
        lvl[0] <= 1'b1;
        wt(SETTLE);
        rdc(STATUS_ADDR, 32'h30000, 32'h10000, "lvl_on");
        lvl[0] <= 1'b0;
        wt(SETTLE);
        rdc(STATUS_ADDR, 32'h30000, 32'h0, "lvl_off");
        lvl[2] <= 1'b1;
        wt(SETTLE);
        rdc(STATUS_ADDR, 32'h30000, 32'h30000, "dim_on");
        wt(RAMP);
        rdc(STATUS_ADDR, 32'h3f3f, 32'h3e3e, "dim_top");
        lvl[2] <= 1'b0;
        wt(SETTLE);
        rdc(STATUS_ADDR, 32'h30000, 32'h0, "dim_off");
        chat <= 1'b0;
        for (int p = 1; p >= 0; p--) begin
            apb(1'b1, CONFIG_ADDR, {29'h0, p[0], 2'b10});
            wt(2);
            pd = pin[2];
            pa = aux_en;
            repeat (64) begin
                lvl[2] <= seed[7];
                @(posedge clk);
                chk("main_ext", ext_exp(pd, p[0]), main);
                chk("aux", pa, aux_out);
                pd = pin[2];
                pa = aux_en;
            end
        end
        // Internal dimming with negative polarity
        apb(1'b1, CONFIG_ADDR, 32'h0);
        lvl[2] <= 1'b1;
        wt(SETTLE);
        rdc(STATUS_ADDR, 32'h30000, 32'h0, "neg_dim_off");
        lvl[2] <= 1'b0;
        wt(SETTLE);
        rdc(STATUS_ADDR, 32'h30000, 32'h30000, "neg_dim_on");
        report_and_stop();
    end
endmodule // led_fade_dimming_control_bench

// ### tb/lfd_assertions.sv
`timescale 1ns/1ns
module lfd_assertions #(
    parameter int DEBOUNCE_CYC = 8,
    parameter int PWM_TICK_CYC = 2
) (
    input wire logic               clk,
    input wire logic               rst_n,
    input lfd_pkg::lfd_apb_req_type apb_req,
    input lfd_pkg::lfd_apb_rsp_type apb_rsp,
    input wire logic [1:0]         channel_toggle_input,
    input wire logic               aux_enable_input,
    input wire logic               dim_input,
    input wire logic [1:0]         main_led_channel,
    input wire logic               aux_led_channel
);
    import lfd_pkg::*;
    // ----
    // Shadow of the mode register and time since reset
    // ----
    logic        acc;
    logic        mapped;
    logic [2:0]  cfg_reg;
    logic [15:0] cnt_reg;
    logic        ext_reg;
    assign acc = apb_req.psel && apb_req.penable;
    assign mapped = apb_req.paddr inside {CONFIG_ADDR, FADE_TIME_ADDR, STATUS_ADDR};

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg_reg <= CONFIG_RESET;
            cnt_reg <= 16'h0;
            ext_reg <= 1'b0;
        end else begin
            if (acc && apb_req.pwrite && apb_rsp.pready && apb_req.paddr == CONFIG_ADDR)
                cfg_reg <= apb_req.pwdata[2:0];
            if (cnt_reg != 16'hffff)
                cnt_reg <= cnt_reg + 16'h1;
            ext_reg <= ext_reg | cfg_reg[1];
        end
    end

    a_aux_follow: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n) |-> aux_led_channel == $past(aux_enable_input))
        else $error("aux output does not follow enable");
    a_reset_off: assert property (@(posedge clk)
        !rst_n |=> main_led_channel == 2'b00 && !aux_led_channel && !apb_rsp.pready)
        else $error("outputs not off in reset");
    a_ext_follow: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n) && $past(cfg_reg[1]) |->
        main_led_channel == {2{$past(dim_input) == $past(cfg_reg[2])}})
        else $error("external dim not followed");
    a_no_early_on: assert property (@(posedge clk) disable iff (!rst_n)
        !ext_reg && cnt_reg <= DEBOUNCE_CYC |-> main_led_channel == 2'b00)
        else $error("main on before debounce");
    a_pready_wait: assert property (@(posedge clk) disable iff (!rst_n)
        acc && !$past(acc) |-> !apb_rsp.pready ##1 apb_rsp.pready)
        else $error("wrong wait states");
    a_pready_one: assert property (@(posedge clk) disable iff (!rst_n)
        apb_rsp.pready |=> !apb_rsp.pready)
        else $error("pready held too long");
    a_pready_access: assert property (@(posedge clk) disable iff (!rst_n)
        apb_rsp.pready |-> acc)
        else $error("pready outside access");
    a_slverr_map: assert property (@(posedge clk) disable iff (!rst_n)
        apb_rsp.pready |-> apb_rsp.pslverr == !mapped)
        else $error("pslverr wrong for address");
    a_err_zero: assert property (@(posedge clk) disable iff (!rst_n)
        apb_rsp.pready && apb_rsp.pslverr |-> apb_rsp.prdata == 32'h0)
        else $error("error read not zero");

    c_unmapped: cover property (@(posedge clk) apb_rsp.pready && apb_rsp.pslverr);
    c_ext_on: cover property (@(posedge clk) cfg_reg[1] && main_led_channel == 2'b11);
    c_int_on: cover property (@(posedge clk) !cfg_reg[1] && main_led_channel == 2'b11);
endmodule // lfd_assertions

bind lfd_top lfd_assertions #(
    .DEBOUNCE_CYC(DEBOUNCE_CYC),
    .PWM_TICK_CYC(PWM_TICK_CYC)
) i_lfd_assertions (
    .clk(clk),
    .rst_n(rst_n),
    .apb_req(apb_req),
    .apb_rsp(apb_rsp),
    .channel_toggle_input(channel_toggle_input),
    .aux_enable_input(aux_enable_input),
    .dim_input(dim_input),
    .main_led_channel(main_led_channel),
    .aux_led_channel(aux_led_channel)
);

// ### tb/lfd_switch_model.sv
`timescale 1ns/1ns
module lfd_switch_model #(
    parameter int W = 3
) (
    input  wire logic         clk,
    input  wire logic [W-1:0] level,
    input  wire logic         chatter,
    output logic      [W-1:0] pin
);
    logic [W-1:0] last_reg;
    logic [W-1:0] chg_reg;
    logic [2:0]   cnt_reg;

    initial begin
        pin = '0;
        last_reg = '0;
        chg_reg = '0;
        cnt_reg = 3'h0;
    end

    // Contacts bounce a few cycles on each change, then settle
    always @(posedge clk) begin
        last_reg <= level;
        if (chatter && level != last_reg) begin
            cnt_reg <= 3'h4;
            chg_reg <= level ^ last_reg;
        end else if (cnt_reg != 3'h0) begin
            cnt_reg <= cnt_reg - 3'h1;
        end
        pin <= (cnt_reg != 3'h0) ? (pin ^ chg_reg) : level;
    end
endmodule // lfd_switch_model
